/* hdl/csic_pkg.sv */
package csic_pkg;
  // ==========================================================
  // register map (byte addresses on apb)
  localparam logic [7:0] ADDR_BWS = 8'h00;
  localparam logic [7:0] ADDR_ISE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;

  // ==========================================================
  // reset values and writable bits
  localparam logic [15:0] BWS_RESET = 16'h200f;
  localparam logic [15:0] BWS_WMASK = 16'h21ff;
  localparam logic [15:0] ISE_RESET = 16'hffff;

  // ==========================================================
  // field positions
  localparam int BWS_IOE = 8;
  localparam int BWS_LG_LSB = 4;
  localparam int BWS_SZ_LSB = 0;
  localparam int ISE_IW_LSB = 8;
  localparam int ISE_CW_LSB = 4;
  localparam int ISE_SW_LSB = 0;

  // ==========================================================
  // counts
  localparam logic [1:0] GAP_MAX = 2'h3;
  localparam int SPACES = 4;

  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_WORD = 2'h1,
    W_LONG = 2'h2
  } csic_width_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE = 4'h2,
    ST_STROBE = 4'h4,
    ST_POST = 4'h8
  } csic_state_e;
endpackage

/* hdl/csic_cfg_if.sv */
interface csic_cfg_if;
  logic [15:0] ise;
  logic prev_valid;
  logic prev_read;
  logic [1:0] prev_space;
  logic [1:0] next_space;
  logic next_write;
  logic [1:0] need;

  modport ctrl (
    output ise, prev_valid, prev_read, prev_space, next_space, next_write,
    input need
  );
  modport calc (
    input ise, prev_valid, prev_read, prev_space, next_space, next_write,
    output need
  );
endinterface

/* hdl/csic_width_sel.sv */
module csic_width_sel (
  // settings of one space
  input wire logic long_flag,
  input wire logic size_bit,
  // width forced from outside the register
  input wire logic override_en,
  input wire csic_pkg::csic_width_e override_width,
  // result
  output csic_pkg::csic_width_e width
);
  always_comb begin
    if (override_en) begin
      width = override_width;
    end else if (long_flag) begin
      width = csic_pkg::W_LONG;
    end else if (size_bit) begin
      width = csic_pkg::W_WORD;
    end else begin
      width = csic_pkg::W_BYTE;
    end
  end
endmodule

/* hdl/csic_idle_calc.sv */
module csic_idle_calc (
  // previous and next access, settings
  csic_cfg_if.calc cfg
);
  logic [1:0] iw;
  logic [1:0] cw;
  logic same;

  // the previous space's field decides the count
  assign iw = cfg.ise[csic_pkg::ISE_IW_LSB + 2 * cfg.prev_space +: 2]; // [RULE12] [RULE13]
  assign cw = {1'b0, cfg.ise[csic_pkg::ISE_CW_LSB + cfg.next_space]};
  assign same = cfg.prev_space == cfg.next_space;

  always_comb begin
    if (!cfg.prev_valid) begin
      cfg.need = 2'h0;
    end else if (cfg.prev_read && cfg.next_write && same) begin
      cfg.need = (iw > cw) ? iw : cw; // [RULE11] [RULE15]
    end else if (cfg.prev_read && !same) begin
      cfg.need = iw; // [RULE10]
    end else if (same) begin
      cfg.need = cw; // [RULE14]
    end else begin
      cfg.need = 2'h0;
    end
  end
endmodule

/* hdl/csic_top.sv */
// What this block does
// [RULE1] space 1 long flag clear: width from size bit; set: 32-bit; resets clear.
// [RULE2] space 0 long flag clear: width from size bit; set: 32-bit; resets clear.
// [RULE3] space 3 ordinary, long clear: size bit 0 byte, 1 word; resets 1.
// [RULE4] space 3 multiplexed: ignore long and size, width from address bit fourteen.
// [RULE5] space 3 long flag set: ordinary space 3 is 32-bit, size bit ignored.
// [RULE6] space 2 size bit: 0 byte, 1 word, resets 1, ignored when long.
// [RULE7] space 1 size bit: 0 byte, 1 word, resets 1, ignored when long.
// [RULE8] space 0 register width only with rom enabled, else mode pins decide.
// [RULE9] idle register resets to all ones, survives manual reset.
// [RULE10] after a read, idles before access to another space.
// [RULE11] read then write to same space also gets between-cycle idles.
// [RULE12] idle count comes from the previous access's space.
// [RULE13] two-bit idle field per space: 0 to 3 idles, resets to 3.
// [RULE14] same-space back-to-back: continuous bit 1 negates select for one idle.
// [RULE15] write after read: larger of between-cycle and continuous idles.
// [RULE16] extension bit adds a cycle before and after, strobes inside select.
// [RULE17] multiplex enable selects space 3 mode; bit fourteen 0 byte, 1 word.
// [RULE18] space 2 long flag clear: width from size bit; set: 32-bit; resets clear.
// [RULE19] space 3 long flag clear: size bit; set: 32-bit ordinary; resets clear.
// [RULE20] setting changes apply from the next bus cycle, never mid-cycle.
module csic_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic manual_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic rom_enable_pin,
  input wire logic [1:0] cs0_width_pin,
  // access request from the core
  input wire logic req_valid,
  input wire logic [1:0] req_space,
  input wire logic req_write,
  input wire logic req_addr_bit_fourteen,
  output logic req_ack,
  // external bus
  output logic [3:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] bus_width
);
  // ==========================================================
  // registers
  logic [15:0] bws_r;
  logic [15:0] ise_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic wr_en;
  logic rd_phase;
  logic [31:0] rd_mux;
  logic addr_ok;

  assign wr_en = psel && penable && pready_r && pwrite;
  assign rd_phase = psel && penable && !pready_r;
  assign addr_ok = paddr == csic_pkg::ADDR_BWS || paddr == csic_pkg::ADDR_ISE
    || paddr == csic_pkg::ADDR_STAT;

  // power-on reset only: a manual reset leaves the settings alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bws_r <= csic_pkg::BWS_RESET; // [RULE1] [RULE2] [RULE3] [RULE6] [RULE7]
      ise_r <= csic_pkg::ISE_RESET; // [RULE9] [RULE13]
    end else if (wr_en && paddr == csic_pkg::ADDR_BWS) begin
      bws_r <= pwdata[15:0] & csic_pkg::BWS_WMASK;
    end else if (wr_en && paddr == csic_pkg::ADDR_ISE) begin
      ise_r <= pwdata[15:0];
    end
  end

  // one wait state so that every apb output comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= rd_phase;
      pslverr_r <= rd_phase && !addr_ok;
      if (rd_phase) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  logic rom_meta_r;
  logic rom_en_s;
  logic [1:0] mode_meta_r;
  logic [1:0] mode_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_meta_r <= 1'b0;
      rom_en_s <= 1'b0;
      mode_meta_r <= 2'h0;
      mode_s <= 2'h0;
    end else begin
      rom_meta_r <= rom_enable_pin;
      rom_en_s <= rom_meta_r;
      mode_meta_r <= cs0_width_pin;
      mode_s <= mode_meta_r;
    end
  end

  // ==========================================================
  // width of each space
  csic_pkg::csic_width_e sp_width [csic_pkg::SPACES];
  logic [3:0] ovr_en;
  csic_pkg::csic_width_e ovr_w [csic_pkg::SPACES];
  logic multiplex_enable;

  assign multiplex_enable = bws_r[csic_pkg::BWS_IOE];

  always_comb begin
    ovr_en = {multiplex_enable, 2'b00, !rom_en_s}; // [RULE4] [RULE8] [RULE17]
    ovr_w[0] = csic_pkg::csic_width_e'(mode_s);
    ovr_w[1] = csic_pkg::W_BYTE;
    ovr_w[2] = csic_pkg::W_BYTE;
    ovr_w[3] = req_addr_bit_fourteen ? csic_pkg::W_WORD : csic_pkg::W_BYTE; // [RULE17]
  end

  for (genvar i = 0; i < csic_pkg::SPACES; i++) begin : g_width
    csic_width_sel u_sel (
      .long_flag(bws_r[csic_pkg::BWS_LG_LSB + i]), // [RULE5] [RULE18] [RULE19]
      .size_bit(bws_r[csic_pkg::BWS_SZ_LSB + i]),
      .override_en(ovr_en[i]),
      .override_width(ovr_w[i]),
      .width(sp_width[i])
    );
  end

  // ==========================================================
  // cycle sequencer
  csic_pkg::csic_state_e state_r;
  csic_pkg::csic_state_e state_nxt;
  logic [1:0] gap_r;
  logic prev_valid_r;
  logic prev_read_r;
  logic [1:0] prev_space_r;
  logic [1:0] cur_space_r;
  logic cur_write_r;
  logic cur_ext_r;
  logic [1:0] bus_width_r;
  logic [3:0] cs_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic ack_r;
  logic last;
  logic gap_ok;
  logic accept;
  logic ext_req;
  csic_cfg_if cfg ();

  assign cfg.ise = ise_r;
  assign cfg.prev_valid = prev_valid_r;
  assign cfg.prev_read = prev_read_r;
  assign cfg.prev_space = prev_space_r;
  assign cfg.next_space = req_space;
  assign cfg.next_write = req_write;

  csic_idle_calc u_idle (
    .cfg(cfg.calc)
  );

  assign ext_req = ise_r[csic_pkg::ISE_SW_LSB + req_space];
  assign last = (state_r == csic_pkg::ST_STROBE && !cur_ext_r)
    || state_r == csic_pkg::ST_POST;
  // the current idle cycle counts as one, so gap_r + 1 idles are on the bus
  assign gap_ok = (state_r == csic_pkg::ST_IDLE) ?
    ({1'b0, gap_r} + 3'h1 >= {1'b0, cfg.need}) : (cfg.need == 2'h0); // [RULE10] [RULE14]
  assign accept = req_valid && !ack_r && (state_r == csic_pkg::ST_IDLE || last) && gap_ok;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      csic_pkg::ST_IDLE: begin
        if (accept) begin
          state_nxt = ext_req ? csic_pkg::ST_PRE : csic_pkg::ST_STROBE; // [RULE16]
        end
      end
      csic_pkg::ST_PRE: begin
        state_nxt = csic_pkg::ST_STROBE;
      end
      csic_pkg::ST_STROBE: begin
        if (cur_ext_r) begin
          state_nxt = csic_pkg::ST_POST; // [RULE16]
        end else if (accept) begin
          state_nxt = ext_req ? csic_pkg::ST_PRE : csic_pkg::ST_STROBE;
        end else begin
          state_nxt = csic_pkg::ST_IDLE;
        end
      end
      csic_pkg::ST_POST: begin
        if (accept) begin
          state_nxt = ext_req ? csic_pkg::ST_PRE : csic_pkg::ST_STROBE;
        end else begin
          state_nxt = csic_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = csic_pkg::ST_IDLE;
      end
    endcase
    if (manual_reset) begin
      state_nxt = csic_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= csic_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // idle cycles elapsed since the last bus cycle ended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 2'h0;
    end else if (state_r != csic_pkg::ST_IDLE || manual_reset) begin
      gap_r <= 2'h0;
    end else if (gap_r != csic_pkg::GAP_MAX) begin
      gap_r <= gap_r + 2'h1;
    end
  end

  // settings are sampled once per cycle so a write cannot reshape it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_space_r <= 2'h0;
      cur_write_r <= 1'b0;
      cur_ext_r <= 1'b0;
      bus_width_r <= 2'h0;
      prev_valid_r <= 1'b0;
      prev_read_r <= 1'b0;
      prev_space_r <= 2'h0;
    end else if (manual_reset) begin
      prev_valid_r <= 1'b0;
    end else if (accept && !manual_reset) begin
      cur_space_r <= req_space; // [RULE20]
      cur_write_r <= req_write;
      cur_ext_r <= ext_req;
      bus_width_r <= sp_width[req_space];
      prev_valid_r <= 1'b1;
      prev_read_r <= !req_write;
      prev_space_r <= req_space;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_r <= 4'hf;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      ack_r <= 1'b0;
    end else begin
      ack_r <= accept && !manual_reset;
      if (state_nxt == csic_pkg::ST_IDLE) begin
        cs_n_r <= 4'hf;
      end else if (accept) begin
        cs_n_r <= ~(4'h1 << req_space);
      end
      // strobes only in the middle state keep them inside the select
      rd_n_r <= !(state_nxt == csic_pkg::ST_STROBE && !(accept ? req_write : cur_write_r));
      wr_n_r <= !(state_nxt == csic_pkg::ST_STROBE && (accept ? req_write : cur_write_r));
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      csic_pkg::ADDR_BWS: rd_mux = {16'h0, bws_r};
      csic_pkg::ADDR_ISE: rd_mux = {16'h0, ise_r};
      csic_pkg::ADDR_STAT: rd_mux = {22'h0, gap_r, bus_width_r, cur_space_r, state_r};
      default: rd_mux = 32'h0;
    endcase
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign req_ack = ack_r;
  assign chip_select_n = cs_n_r;
  assign read_strobe_n = rd_n_r;
  assign write_strobe_n = wr_n_r;
  assign bus_width = bus_width_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cs_on;
  assign cs_on = cs_n_r != 4'hf;

  sequence s_pre_cycle;
    $rose(cs_on) && rd_n_r && wr_n_r;
  endsequence

  sequence s_strobe_then_drop;
    (!rd_n_r || !wr_n_r) ##1 (rd_n_r && wr_n_r && cs_on);
  endsequence

  width0_long_a: assert property (rom_en_s && bws_r[4] // [RULE2]
    |-> sp_width[0] == csic_pkg::W_LONG)
    else $error("space 0 long flag not honoured");
  width0_pin_a: assert property (!rom_en_s |-> sp_width[0] == mode_s) // [RULE8]
    else $error("space 0 width not from mode pins");
  width1_sz_a: assert property (!bws_r[5] |-> sp_width[1] == {1'b0, bws_r[1]}) // [RULE7]
    else $error("space 1 size bit not honoured");
  width3_mux_a: assert property (multiplex_enable |-> sp_width[3] == {1'b0, req_addr_bit_fourteen}) // [RULE4]
    else $error("space 3 multiplexed width wrong");
  width3_long_a: assert property (!multiplex_enable && bws_r[7] |-> sp_width[3] == csic_pkg::W_LONG) // [RULE5]
    else $error("space 3 long width wrong");
  strobe_in_cs_a: assert property (!rd_n_r || !wr_n_r |-> cs_on) // [RULE16]
    else $error("strobe outside chip select");
  // a manual reset may cut the cycle short, so it is left out of both extension checks
  ext_before_a: assert property ((s_pre_cycle and (cur_ext_r && !manual_reset)) // [RULE16]
    |=> !rd_n_r || !wr_n_r)
    else $error("extension cycle before strobe missing");
  ext_after_a: assert property (cur_ext_r && !rd_n_r && !manual_reset // [RULE16]
    |-> s_strobe_then_drop)
    else $error("extension cycle after strobe missing");
  rd_other_a: assert property (accept && prev_valid_r && prev_read_r // [RULE12]
    && req_space != prev_space_r |-> cfg.need == ise_r[8 + 2 * prev_space_r +: 2])
    else $error("idle count not from previous space");
  rd_wr_max_a: assert property (accept && prev_valid_r && prev_read_r && req_write // [RULE15]
    && req_space == prev_space_r |-> cfg.need >= ise_r[8 + 2 * prev_space_r +: 2])
    else $error("write after read idles too short");
  same_cont_a: assert property (accept && prev_valid_r && !prev_read_r // [RULE14]
    && req_space == prev_space_r |-> cfg.need == {1'b0, ise_r[4 + req_space]})
    else $error("continuous access idle wrong");
  width_hold_a: assert property (state_r != csic_pkg::ST_IDLE && !last // [RULE20]
    && !manual_reset |=> $stable(bus_width_r))
    else $error("width changed inside a bus cycle");
  keep_manual_a: assert property (manual_reset && !wr_en // [RULE9]
    |=> $stable(ise_r) && $stable(bws_r))
    else $error("settings lost on manual reset");
endmodule

/* test/csic_ext_mem.sv */
// ==========================================================
// external device on the chip-select spaces: it watches the pins only
module csic_ext_mem (
  // bus pins
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  // observations
  output logic [7:0] cs_len_r,
  output logic [7:0] strobe_err_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_r;

  // ==========================================================
  // length of the last select assertion, latched when it ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 8'h00;
      cs_len_r <= 8'h00;
    end else if (chip_select_n != 4'hf) begin
      run_r <= run_r + 8'h01;
    end else if (run_r != 8'h00) begin
      cs_len_r <= run_r;
      run_r <= 8'h00;
    end
  end

  // ==========================================================
  // a strobe seen while no space is selected would corrupt a slow device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_err_r <= 8'h00;
    end else if ((!read_strobe_n || !write_strobe_n) && chip_select_n == 4'hf) begin
      strobe_err_r <= strobe_err_r + 8'h01;
    end
  end
endmodule

/* test/csic_tb_top.sv */
module csic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, manual_reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rom_enable_pin, req_valid, req_write, req_addr_bit_fourteen, req_ack;
  logic read_strobe_n, write_strobe_n, err;
  logic [1:0] cs0_width_pin, req_space, bus_width, wd;
  logic [3:0] chip_select_n;
  logic [7:0] cs_len, strobe_err;
  int n, error_cnt, n_checks;

  csic_top dut (.pclk(pclk), .presetn(presetn), .manual_reset(manual_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rom_enable_pin(rom_enable_pin),
    .cs0_width_pin(cs0_width_pin), .req_valid(req_valid), .req_space(req_space),
    .req_write(req_write), .req_addr_bit_fourteen(req_addr_bit_fourteen), .req_ack(req_ack),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .bus_width(bus_width));
  csic_ext_mem mem (.pclk(pclk), .presetn(presetn), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .cs_len_r(cs_len),
    .strobe_err_r(strobe_err));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // apb master: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, experr});
  endtask

  // request held until its acknowledge is sampled; n counts edges waited
  task automatic acc(input logic [1:0] sp, input logic w);
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= w;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (req_ack !== 1'b1 && n < 50);
    wd = bus_width;
  endtask

  task automatic rel;
    req_valid <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic wchk(input logic [1:0] sp, input logic a14, input logic [1:0] exp);
    req_addr_bit_fourteen <= a14;
    acc(sp, 1'b0);
    rel();
    chk({30'h0, wd}, {30'h0, exp});
  endtask

  // two back-to-back requests; the second waits one cycle plus the owed idles
  task automatic pair(input logic [1:0] s1, input logic w1, input logic [1:0] s2,
                      input logic w2, input int need);
    acc(s1, w1);
    acc(s2, w2);
    rel();
    if (need > 0) chk(n, 1 + need);
    else chk({31'h0, n <= 2}, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    manual_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rom_enable_pin = 1'b1;
    cs0_width_pin = 2'h0;
    req_valid = 1'b0;
    req_space = 2'h0;
    req_write = 1'b0;
    req_addr_bit_fourteen = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(csic_pkg::ADDR_BWS, 32'h200f, 1'b0);
    rdc(csic_pkg::ADDR_ISE, 32'hffff, 1'b0);
    rdc(8'h0c, 32'h0, 1'b1);
    apb(1'b1, csic_pkg::ADDR_BWS, 32'hffff);
    rdc(csic_pkg::ADDR_BWS, 32'h21ff, 1'b0);
    // widths: size bits, long flags, multiplexed space 3, mode pins
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h200f);
    for (int s = 0; s < 4; s++) wchk(s[1:0], 1'b0, csic_pkg::W_WORD);
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h2000);
    for (int s = 0; s < 4; s++) wchk(s[1:0], 1'b1, csic_pkg::W_BYTE);
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h20f0);
    for (int s = 0; s < 4; s++) wchk(s[1:0], 1'b0, csic_pkg::W_LONG);
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h21f0);
    wchk(2'h2, 1'b0, csic_pkg::W_LONG);
    wchk(2'h3, 1'b0, csic_pkg::W_BYTE);
    wchk(2'h3, 1'b1, csic_pkg::W_WORD);
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h20f8);
    wchk(2'h3, 1'b0, csic_pkg::W_LONG);
    // pins pass two flip-flops: let them settle before the next request
    rom_enable_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    wchk(2'h0, 1'b0, csic_pkg::W_BYTE);
    cs0_width_pin <= 2'h1;
    repeat (3) @(posedge pclk);
    wchk(2'h0, 1'b0, csic_pkg::W_WORD);
    rom_enable_pin <= 1'b1;
    apb(1'b1, csic_pkg::ADDR_BWS, 32'h200f);
    // idles between cycles, no extension
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, csic_pkg::ADDR_ISE, {22'h0, c[1:0], 8'h00});
      pair(2'h0, 1'b0, 2'h1, 1'b0, c);
    end
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0900);
    pair(2'h1, 1'b0, 2'h0, 1'b0, 2);
    pair(2'h0, 1'b0, 2'h1, 1'b0, 1);
    pair(2'h0, 1'b1, 2'h1, 1'b0, 0);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0010);
    pair(2'h0, 1'b1, 2'h0, 1'b1, 1);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0000);
    pair(2'h0, 1'b1, 2'h0, 1'b1, 0);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h3040);
    pair(2'h2, 1'b0, 2'h2, 1'b1, 3);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0040);
    pair(2'h2, 1'b0, 2'h2, 1'b1, 1);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h2000);
    pair(2'h2, 1'b0, 2'h2, 1'b1, 2);
    // select extension
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0001);
    acc(2'h0, 1'b1);
    rel();
    chk({24'h0, cs_len}, 32'h3);
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h0000);
    acc(2'h0, 1'b0);
    rel();
    chk({24'h0, cs_len}, 32'h1);
    chk({24'h0, strobe_err}, 32'h0);
    // manual reset keeps both registers
    apb(1'b1, csic_pkg::ADDR_ISE, 32'h5a3c);
    manual_reset <= 1'b1;
    repeat (3) @(posedge pclk);
    manual_reset <= 1'b0;
    rdc(csic_pkg::ADDR_ISE, 32'h5a3c, 1'b0);
    rdc(csic_pkg::ADDR_BWS, 32'h200f, 1'b0);
    end_sim();
  end
endmodule
